// ===== hw/pdc_defines.vh
/*
 register offsets, field positions, reset values and encodings of the pll divider
 and trigger output control block. assumes byte-wide registers on a simple port.
*/
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH
// ***********************************
// register offsets
// ***********************************
`define PDC_OFS_PRESCALER 8'h3d
`define PDC_OFS_LOOP_N 8'h3e
`define PDC_OFS_OSC_BIAS 8'h3f
`define PDC_OFS_EMPHASIS 8'h48
`define PDC_OFS_TRIGGER 8'h57
// ***********************************
// reset values
// ***********************************
`define PDC_RST_PRESCALER 8'h00
`define PDC_RST_LOOP_N 8'h20
`define PDC_RST_OSC_BIAS 8'h4f
`define PDC_RST_EMPHASIS 8'h00
`define PDC_RST_TRIGGER 8'h00
// ***********************************
// writable field masks, reserved bits stay zero
// ***********************************
`define PDC_MSK_PRESCALER 8'h0f
`define PDC_MSK_LOOP_N 8'h3f
`define PDC_MSK_OSC_BIAS 8'h7f
`define PDC_MSK_EMPHASIS 8'h0f
`define PDC_MSK_TRIGGER 8'h87
// ***********************************
// field positions
// ***********************************
`define PDC_TRIG_EN_BIT 7
`define PDC_SEL_UI16 3'h0
`define PDC_SEL_UI32 3'h1
`define PDC_SEL_UI64 3'h2
`define PDC_SEL_STAMP 3'h3
`define PDC_HALF_UI16 6'h07
`define PDC_HALF_UI32 6'h0f
`define PDC_HALF_UI64 6'h1f
// ***********************************
// prescaler terminal counts, ratio minus one
// ***********************************
`define PDC_VLAST_DIV5 3'h4
`define PDC_VLAST_DIV4 3'h3
`define PDC_VLAST_DIV3 3'h2
`define PDC_PLAST_DIV1 2'h0
`define PDC_PLAST_DIV2 2'h1
`define PDC_PLAST_DIV4 2'h3
`endif

// ===== hw/pdc_ctrl.v
/*
 pll feedback divider configuration, lane pre-emphasis and trigger output logic.
 assumes a single-cycle byte register port on clk, the vco and serializer bit clock
 modelled as clk ticks, and software keeping the pll in reset while dividers change.
*/
// How it works
// - second prescaler: 1, 2, 4, 3 reserved
// - first prescaler: 5, 4, 3, 3 reserved
// - third divider by n, 1..63, reset 32
// - one pre-emphasis value drives all lanes
// - enable bit gates trigger buffer and divider
// - select 16/32/64 ui clock or timestamp
// - clock modes derive from serializer clock
`timescale 1ns/100ps
`include "pdc_defines.vh"
module pdc_ctrl #(
    parameter LANES = 8
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // pll model clocks and control
    input wire pll_hold_reset,
    output reg sample_clk_tick,
    output reg feedback_clk_tick,
    output wire [6:0] oscillator_bias_level,
    // serializer
    input wire ser_reinit,
    output wire [4*LANES-1:0] lane_preemphasis,
    // trigger output
    input wire timestamp_input,
    output reg trigger_output,
    output reg trigger_output_oe
);
    // ***********************************
    // register file
    // ***********************************
    reg [7:0] pll_loop_prescaler_ctrl_reg;
    reg [7:0] pll_loop_divider_n_reg;
    reg [7:0] oscillator_bias_level_ctrl_reg;
    reg [7:0] lane_emphasis_ctrl_reg;
    reg [7:0] trigger_out_ctrl_reg;
    reg [2:0] v_cnt_reg;
    reg [1:0] p_cnt_reg;
    reg [5:0] n_cnt_reg;
    reg [5:0] ui_cnt_reg;
    reg stamp_reg;
    wire trig_en;
    wire [2:0] trig_sel;
    reg [2:0] v_last;
    reg [1:0] p_last;
    reg [5:0] half_ui;
    wire v_wrap;
    wire p_wrap;
    wire n_wrap;
    wire ui_wrap;

    assign trig_en = trigger_out_ctrl_reg[`PDC_TRIG_EN_BIT];
    assign trig_sel = trigger_out_ctrl_reg[2:0];
    assign oscillator_bias_level = oscillator_bias_level_ctrl_reg[6:0];

    // writes store only defined bits; reserved bits read zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pll_loop_prescaler_ctrl_reg <= `PDC_RST_PRESCALER;
            pll_loop_divider_n_reg <= `PDC_RST_LOOP_N;
            oscillator_bias_level_ctrl_reg <= `PDC_RST_OSC_BIAS;
            lane_emphasis_ctrl_reg <= `PDC_RST_EMPHASIS;
            trigger_out_ctrl_reg <= `PDC_RST_TRIGGER;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `PDC_OFS_PRESCALER:
                    pll_loop_prescaler_ctrl_reg <= reg_wdata & `PDC_MSK_PRESCALER;
                `PDC_OFS_LOOP_N:
                    pll_loop_divider_n_reg <= reg_wdata & `PDC_MSK_LOOP_N;
                `PDC_OFS_OSC_BIAS:
                    oscillator_bias_level_ctrl_reg <= reg_wdata & `PDC_MSK_OSC_BIAS;
                `PDC_OFS_EMPHASIS:
                    lane_emphasis_ctrl_reg <= reg_wdata & `PDC_MSK_EMPHASIS;
                `PDC_OFS_TRIGGER:
                    trigger_out_ctrl_reg <= reg_wdata & `PDC_MSK_TRIGGER;
                default: ;
            endcase
        end
    end

    // read data registered; unmapped offsets return zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PDC_OFS_PRESCALER: reg_rdata <= pll_loop_prescaler_ctrl_reg;
                `PDC_OFS_LOOP_N: reg_rdata <= pll_loop_divider_n_reg;
                `PDC_OFS_OSC_BIAS: reg_rdata <= oscillator_bias_level_ctrl_reg;
                `PDC_OFS_EMPHASIS: reg_rdata <= lane_emphasis_ctrl_reg;
                `PDC_OFS_TRIGGER: reg_rdata <= trigger_out_ctrl_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ***********************************
    // feedback divider chain
    // ***********************************
    // reserved codes fall back to the default ratio rather than stalling the loop
    always @*
    begin
        case (pll_loop_prescaler_ctrl_reg[1:0])
            2'h1: v_last = `PDC_VLAST_DIV4;
            2'h2: v_last = `PDC_VLAST_DIV3;
            default: v_last = `PDC_VLAST_DIV5;
        endcase
        case (pll_loop_prescaler_ctrl_reg[3:2])
            2'h1: p_last = `PDC_PLAST_DIV2;
            2'h2: p_last = `PDC_PLAST_DIV4;
            default: p_last = `PDC_PLAST_DIV1;
        endcase
    end

    assign v_wrap = (v_cnt_reg >= v_last);
    assign p_wrap = (p_cnt_reg >= p_last);
    // zero n is unsupported; treated as divide by one
    assign n_wrap = (n_cnt_reg + 6'h01 >= pll_loop_divider_n_reg[5:0]);

    // each stage advances only on its predecessor's output tick
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            v_cnt_reg <= 3'h0;
            p_cnt_reg <= 2'h0;
            n_cnt_reg <= 6'h00;
            sample_clk_tick <= 1'b0;
            feedback_clk_tick <= 1'b0;
        end
        else if (pll_hold_reset)
        begin
            v_cnt_reg <= 3'h0;
            p_cnt_reg <= 2'h0;
            n_cnt_reg <= 6'h00;
            sample_clk_tick <= 1'b0;
            feedback_clk_tick <= 1'b0;
        end
        else
        begin
            v_cnt_reg <= v_wrap ? 3'h0 : v_cnt_reg + 3'h1;
            sample_clk_tick <= v_wrap && p_wrap;
            feedback_clk_tick <= 1'b0;
            if (v_wrap)
                p_cnt_reg <= p_wrap ? 2'h0 : p_cnt_reg + 2'h1;
            if (v_wrap && p_wrap)
            begin
                n_cnt_reg <= n_wrap ? 6'h00 : n_cnt_reg + 6'h01;
                feedback_clk_tick <= n_wrap;
            end
        end
    end

    // ***********************************
    // lane pre-emphasis
    // ***********************************
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi = gi + 1)
        begin : g_lane
            assign lane_preemphasis[4*gi+3:4*gi] = lane_emphasis_ctrl_reg[3:0];
        end
    endgenerate

    // ***********************************
    // trigger output
    // ***********************************
    always @*
    begin
        case (trig_sel)
            `PDC_SEL_UI32: half_ui = `PDC_HALF_UI32;
            `PDC_SEL_UI64: half_ui = `PDC_HALF_UI64;
            default: half_ui = `PDC_HALF_UI16;
        endcase
    end

    assign ui_wrap = (ui_cnt_reg >= half_ui);

    // clk stands for the serializer bit clock; reinit restarts the divider,
    // which glitches the output just as the real serializer would
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ui_cnt_reg <= 6'h00;
            stamp_reg <= 1'b0;
            trigger_output <= 1'b0;
            trigger_output_oe <= 1'b0;
        end
        else
        begin
            stamp_reg <= timestamp_input;
            trigger_output_oe <= trig_en;
            if (!trig_en || ser_reinit)
            begin
                ui_cnt_reg <= 6'h00;
                trigger_output <= 1'b0;
            end
            else if (trig_sel == `PDC_SEL_STAMP)
                trigger_output <= stamp_reg;
            else if (trig_sel <= `PDC_SEL_UI64)
            begin
                ui_cnt_reg <= ui_wrap ? 6'h00 : ui_cnt_reg + 6'h01;
                if (ui_wrap)
                    trigger_output <= ~trigger_output;
            end
            else
                trigger_output <= 1'b0; // reserved select idles low
        end
    end
endmodule // pdc_ctrl

// ===== dv/pdc_ctrl_props.sv
/* port checker for pdc_ctrl.
   assumes one clk domain and rst asynchronous, active high. */
`timescale 1ns/100ps
module pdc_ctrl_props #(parameter LANES = 8) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // pll model
    input wire pll_hold_reset,
    input wire sample_clk_tick,
    input wire feedback_clk_tick,
    input wire [6:0] oscillator_bias_level,
    // serializer
    input wire ser_reinit,
    input wire [4*LANES-1:0] lane_preemphasis,
    // trigger output
    input wire timestamp_input,
    input wire trigger_output,
    input wire trigger_output_oe
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
// register fields reach their outputs one edge after the write
property p_bias;
    reg_wr && reg_addr == 8'h3f |=> oscillator_bias_level == $past(reg_wdata[6:0]);
endproperty
a_bias: assert property (p_bias) else $error("bias level wrong");
property p_emw;
    reg_wr && reg_addr == 8'h48 |=> lane_preemphasis[3:0] == $past(reg_wdata[3:0]);
endproperty
a_emw: assert property (p_emw) else $error("emphasis wrong");
property p_emph; lane_preemphasis == {LANES{lane_preemphasis[3:0]}}; endproperty
a_emph: assert property (p_emph) else $error("lanes differ");
// enable reaches the buffer two edges after the write
property p_oe;
    reg_wr && reg_addr == 8'h57 |-> ##2 trigger_output_oe == $past(reg_wdata[7], 2);
endproperty
a_oe: assert property (p_oe) else $error("oe wrong");
property p_off; !trigger_output_oe [*2] |-> !trigger_output; endproperty
a_off: assert property (p_off) else $error("output while off");
property p_fb; feedback_clk_tick |-> sample_clk_tick; endproperty
a_fb: assert property (p_fb) else $error("feedback off grid");
property p_hold; pll_hold_reset |=> !sample_clk_tick && !feedback_clk_tick; endproperty
a_hold: assert property (p_hold) else $error("tick in hold");
// smallest ratio is three, so two quiet cycles follow any tick
property p_gap; sample_clk_tick |=> !sample_clk_tick [*2]; endproperty
a_gap: assert property (p_gap) else $error("ticks too close");
property p_rei; ser_reinit |=> !trigger_output; endproperty
a_rei: assert property (p_rei) else $error("output in reinit");
endmodule // pdc_ctrl_props

// ===== dv/pdc_ctrl_test.sv
/* self-checking bench for pdc_ctrl against a register model.
   assumes clk models vco and serializer bit clock. */
`timescale 1ns/100ps
module pdc_ctrl_test;
logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pll_hold_reset = 0;
logic ser_reinit = 0, timestamp_input = 0;
logic [7:0] reg_addr = 0, reg_wdata = 0;
logic [1:0] h;
wire [7:0] reg_rdata;
wire [6:0] oscillator_bias_level;
wire [31:0] lane_preemphasis;
wire sample_clk_tick, feedback_clk_tick, trigger_output, trigger_output_oe;
wire [2:0] obs = {trigger_output, feedback_clk_tick, sample_clk_tick};
int err_total = 0, comparisons = 0, seed = 28411, n;
logic [7:0] mdl [0:255], msk [0:255];
int vd [4] = '{5, 4, 3, 5}, pd [4] = '{1, 2, 4, 1};
pdc_ctrl uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pll_hold_reset(pll_hold_reset), .sample_clk_tick(sample_clk_tick),
    .feedback_clk_tick(feedback_clk_tick), .oscillator_bias_level(oscillator_bias_level),
    .ser_reinit(ser_reinit), .lane_preemphasis(lane_preemphasis),
    .timestamp_input(timestamp_input), .trigger_output(trigger_output),
    .trigger_output_oe(trigger_output_oe));
initial forever #2.5 clk = ~clk;
task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
endtask
// one idle negedge between accesses keeps strobes single-assigned
task automatic wr(logic [7:0] a, d);
    @(negedge clk);
    reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge clk);
    reg_wr = 0; mdl[a] = d & msk[a];
endtask
task automatic rd(logic [7:0] a);
    @(negedge clk);
    reg_rd = 1; reg_addr = a;
    @(negedge clk);
    reg_rd = 0; chk("rdata", mdl[a], reg_rdata);
endtask
// cycles between two events: tick pulses, or trigger level changes
task automatic span(int i, output int n);
    logic l;
    repeat (2)
    begin
        l = obs[i]; n = 0;
        do begin @(posedge clk); #1; n++; end
        while (n < 3000 && (i < 2 ? obs[i] !== 1'b1 : obs[i] === l));
    end
endtask
task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
initial
begin
    #200000; err_total++; give_verdict;
end
logic [7:0] al [6] = '{8'h3d, 8'h3e, 8'h3f, 8'h48, 8'h57, 8'h00};
initial
begin
    for (int a = 0; a < 256; a++) begin mdl[a] = 0; msk[a] = 0; end
    mdl[8'h3e] = 8'h20; mdl[8'h3f] = 8'h4f;
    msk[8'h3d] = 8'h0f; msk[8'h3e] = 8'h3f; msk[8'h3f] = 8'h7f;
    msk[8'h48] = 8'h0f; msk[8'h57] = 8'h87;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 0;
    foreach (al[i]) rd(al[i]);
    span(1, n); chk("fb_reset", 160, n);
    $display("reset test done");
    // random data, reserved bits must read back zero; trigger kept off
    @(negedge clk) pll_hold_reset = 1;
    foreach (al[i])
    begin
        wr(al[i], $random(seed) & (i == 4 ? 8'h7f : 8'hff));
        rd(al[i]);
    end
    chk("bias", mdl[8'h3f][6:0], oscillator_bias_level);
    chk("emph", {8{mdl[8'h48][3:0]}}, lane_preemphasis);
    $display("register test done");
    for (int k = 0; k < 16; k++)
    begin
        @(negedge clk) pll_hold_reset = 1;
        wr(8'h3d, 8'(k)); wr(8'h3e, 8'(1 + k % 3));
        @(negedge clk) pll_hold_reset = 0;
        span(0, n); chk("sample", vd[k%4] * pd[k/4], n);
        span(1, n); chk("feedback", vd[k%4] * pd[k/4] * (1 + k % 3), n);
    end
    wr(8'h3f, 8'h4a); @(negedge clk); chk("bias", 8'h4a, oscillator_bias_level);
    $display("divider test done");
    for (int s = 0; s < 5; s++)
    begin
        wr(8'h57, 8'(s)); wr(8'h57, 8'h80 | 8'(s));
        if (s < 3) begin span(2, n); chk("half", 8 << s, n); end
        else if (s == 3)
            for (int k = 0; k < 20; k++)
            begin
                @(negedge clk) timestamp_input = $random(seed);
                @(posedge clk) #1 h = {h[0], timestamp_input};
                if (k > 1) chk("tstamp", h[1], trigger_output);
            end
        else begin repeat (40) @(negedge clk); chk("rsv", 0, trigger_output); end
        chk("oe", 1, trigger_output_oe);
        // disable first, keeping the mode, so the next mode change sees it off
        wr(8'h57, 8'(s));
    end
    wr(8'h57, 8'h00); wr(8'h57, 8'h80);
    @(negedge clk) ser_reinit = 1;
    repeat (3) @(negedge clk);
    chk("reinit", 0, trigger_output);
    ser_reinit = 0;
    span(2, n); chk("half", 8, n);
    wr(8'h57, 8'h00); repeat (3) @(negedge clk);
    chk("oe_off", 0, trigger_output_oe); chk("off", 0, trigger_output);
    $display("trigger test done");
    give_verdict;
end
endmodule // pdc_ctrl_test
bind pdc_ctrl pdc_ctrl_props #(.LANES(LANES)) u_props (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pll_hold_reset(pll_hold_reset), .sample_clk_tick(sample_clk_tick),
    .feedback_clk_tick(feedback_clk_tick), .oscillator_bias_level(oscillator_bias_level),
    .ser_reinit(ser_reinit), .lane_preemphasis(lane_preemphasis),
    .timestamp_input(timestamp_input), .trigger_output(trigger_output),
    .trigger_output_oe(trigger_output_oe));
